// *** logic/pcrd_consts.svh ***
// Address, field and reset constants for the program counter and register decode block
`ifndef PCRD_CONSTS_SVH
`define PCRD_CONSTS_SVH
`define PCRD_ADDR_INDIRECT 6'h00
`define PCRD_ADDR_TIMER 6'h01
`define PCRD_ADDR_PC 6'h02
`define PCRD_ADDR_STATUS 6'h03
`define PCRD_ADDR_POINTER 6'h04
`define PCRD_ADDR_PORT5 6'h05
`define PCRD_ADDR_OPER_LAST 6'h0F
`define PCRD_ADDR_COMMON_LO 6'h10
`define PCRD_ADDR_COMMON_HI 6'h1F
`define PCRD_ADDR_BANK_LO 6'h20
`define PCRD_PC_RESET 12'h000
`define PCRD_BYTE_ZERO 8'h00
`define PCRD_STATUS_PAGE_HI 6
`define PCRD_STATUS_PAGE_LO 5
`define PCRD_PTR_BANK_HI 7
`define PCRD_PTR_BANK_LO 6
`define PCRD_PORT5_PAGE_BIT 0
`define PCRD_STACK_DEPTH 8
`define PCRD_STACK_IDX_W 3
`define PCRD_PIN_OPT_RESET 8'h00
`endif

// *** logic/pcrd_pkg.sv ***
// Types for the program counter and register decode block
package pcrd_pkg;
  typedef enum logic [2:0] {
    PCRD_OP_STEP = 3'h0,
    PCRD_OP_JUMP = 3'h1,
    PCRD_OP_CALL = 3'h2,
    PCRD_OP_RET = 3'h3,
    PCRD_OP_RET_LIT = 3'h4,
    PCRD_OP_RET_INT = 3'h5,
    PCRD_OP_ADD_PC = 3'h6,
    PCRD_OP_MOVE_PC = 3'h7
  } pcrd_op_t;
  typedef enum logic [2:0] {
    PCRD_REG_INDIRECT = 3'h0,
    PCRD_REG_SPECIAL = 3'h1,
    PCRD_REG_OPERATIONAL = 3'h2,
    PCRD_REG_CONTROL = 3'h3,
    PCRD_REG_COMMON = 3'h4,
    PCRD_REG_BANKED = 3'h5
  } pcrd_region_t;
  typedef struct packed {
    pcrd_op_t op;
    logic [9:0] target;
    logic [7:0] acc;
  } pcrd_flow_t;
  typedef struct packed {
    logic valid;
    logic control_space;
    logic [5:0] addr;
    logic write;
    logic [7:0] wdata;
  } pcrd_access_t;
  typedef struct packed {
    pcrd_region_t region;
    logic [1:0] bank;
    logic page;
    logic [5:0] addr;
  } pcrd_decode_t;
endpackage : pcrd_pkg

// *** logic/pcrd_return_stack.sv ***
// Return address stack, wraps on overflow and underflow
`timescale 1ns/100ps
`include "pcrd_consts.svh"
module pcrd_return_stack (
  input wire logic clk, // Instruction clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic push, // Push request
  input wire logic pop, // Pop request
  input wire logic [11:0] push_data, // Return address to store
  output logic [11:0] top_data // Current top entry
);
  logic [11:0] entry_reg [`PCRD_STACK_DEPTH];
  logic [`PCRD_STACK_IDX_W-1:0] sp_reg;
  logic [`PCRD_STACK_IDX_W-1:0] sp_next;
  logic [`PCRD_STACK_IDX_W-1:0] top_idx;

  assign top_idx = sp_reg - `PCRD_STACK_IDX_W'(1);
  assign sp_next = push ? sp_reg + `PCRD_STACK_IDX_W'(1) : (pop ? top_idx : sp_reg);
  assign top_data = entry_reg[top_idx];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sp_reg <= '0;
    end else begin
      sp_reg <= sp_next; // see RQ22
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      entry_reg[sp_reg] <= push_data;
    end
  end
endmodule : pcrd_return_stack

// *** logic/pcrd_core.sv ***
// Program counter sequencing and data register address decode
`timescale 1ns/100ps
`include "pcrd_consts.svh"
// How it works
// RQ1 - Reset clears the whole program counter to zero.
// RQ2 - Counter is twelve bits, addressing 4K program words.
// RQ3 - Jump loads the low ten counter bits from the target.
// RQ4 - Call pushes counter plus one and loads low ten bits.
// RQ5 - Every return kind reloads the counter from the stack top.
// RQ6 - Add-to-counter adds accumulator with carry into upper bits.
// RQ7 - Move-to-counter replaces low eight bits, keeps bits eight to eleven.
// RQ8 - Jump and call load bits ten, eleven from page select.
// RQ9 - Location zero accesses the register that the pointer names.
// RQ10 - Timer counts on input edge or each cycle, and is read/write.
// RQ11 - Addresses 10 to 1F map to common registers in every bank.
// RQ12 - Addresses 20 to 3F map into one of four banks.
// RQ13 - Addresses 05 to 0F are operational; control space has two pages.
// RQ14 - Pin priority: peripheral output over input over general I/O.
// RQ15 - Software disables pin-change wake-up on non-general pins.
// RQ16 - Pin options come up disabled after reset.
// RQ17 - Device stays in reset while the low-active reset pin is low.
// RQ18 - Status bits six and five choose one of four program pages.
// RQ19 - Returns leave the page select bits untouched.
// RQ20 - Pointer low six bits address registers, top two select bank.
// RQ21 - Port-5 bit zero selects the control register page.
// RQ22 - Stack depth is a parameter; overflow wraps silently.
module pcrd_core import pcrd_pkg::*; (
  input wire logic clk, // Instruction clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic ext_rst_n, // External reset pin, active low
  input wire logic timer_pin, // External timer input pin
  input wire logic timer_ext_sel, // Timer counts pin edges when high
  input wire pcrd_flow_t flow, // Instruction flow request
  input wire pcrd_access_t access, // Register access request
  input wire logic [3:0] pin_periph_out_en, // Peripheral output claims pin
  input wire logic [3:0] pin_periph_in_en, // Peripheral input claims pin
  input wire logic [3:0] pin_periph_out, // Peripheral output levels
  input wire logic [3:0] pin_gpio_out, // General output levels
  input wire logic [3:0] pin_gpio_oe, // General output enables
  output logic [11:0] program_counter, // Program memory address
  output logic [7:0] rdata, // Register read data
  output pcrd_decode_t decode_out, // Resolved access target
  output logic [1:0] rom_page, // Page select bits
  output logic [7:0] pointer_register, // Indirect pointer
  output logic [7:0] timer_clock_counter, // Timer count
  output logic control_page_select, // Control register page
  output logic [7:0] pin_options, // Pull, drain and wake options
  output logic [3:0] pin_out, // Resolved pin levels
  output logic [3:0] pin_oe, // Resolved pin enables
  output logic in_reset // Core held in reset
);
  logic [11:0] pc_reg;
  logic [11:0] pc_next;
  logic [1:0] page_reg;
  logic [4:0] status_low_reg;
  logic [7:0] ptr_reg;
  logic [7:0] timer_reg;
  logic [7:0] timer_next;
  logic ctl_page_reg;
  logic [7:0] pin_opt_reg;
  logic [3:0] pin_out_reg;
  logic [3:0] pin_oe_reg;
  logic [7:0] rdata_reg;
  pcrd_decode_t decode_reg;
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic tpin_meta_reg;
  logic tpin_sync_reg;
  logic tpin_prev_reg;
  logic in_reset_reg;
  logic [7:0] common_reg [16];
  logic [7:0] bank_reg [4][32];

  // Pin synchronisers
  always_ff @(posedge clk) begin
    rst_meta_reg <= ext_rst_n;
    rst_sync_reg <= rst_meta_reg;
    tpin_meta_reg <= timer_pin;
    tpin_sync_reg <= tpin_meta_reg;
    tpin_prev_reg <= tpin_sync_reg;
  end

  wire core_rst = sys_rst | ~rst_sync_reg; // see RQ17

  // Access decode
  wire is_indirect = access.addr == `PCRD_ADDR_INDIRECT;
  wire [5:0] eff_addr = is_indirect ? ptr_reg[5:0] : access.addr; // see RQ9 see RQ20
  wire [1:0] bank_sel = ptr_reg[`PCRD_PTR_BANK_HI:`PCRD_PTR_BANK_LO]; // see RQ20
  wire is_common = eff_addr >= `PCRD_ADDR_COMMON_LO && eff_addr <= `PCRD_ADDR_COMMON_HI; // see RQ11
  wire is_banked = eff_addr >= `PCRD_ADDR_BANK_LO; // see RQ12
  wire is_oper = eff_addr >= `PCRD_ADDR_PORT5 && eff_addr <= `PCRD_ADDR_OPER_LAST; // see RQ13
  wire is_ctl = access.control_space && is_oper; // see RQ13
  wire [3:0] common_idx = eff_addr[3:0];
  wire [4:0] bank_idx = eff_addr[4:0];
  wire wr = access.valid && access.write && !access.control_space;
  wire wr_timer = wr && eff_addr == `PCRD_ADDR_TIMER;
  wire wr_pc = wr && eff_addr == `PCRD_ADDR_PC;
  wire wr_status = wr && eff_addr == `PCRD_ADDR_STATUS;
  wire wr_ptr = wr && eff_addr == `PCRD_ADDR_POINTER;
  wire wr_port5 = wr && eff_addr == `PCRD_ADDR_PORT5;
  wire wr_pinopt = access.valid && access.write && is_ctl && !ctl_page_reg;
  wire pcrd_region_t region = is_indirect ? PCRD_REG_INDIRECT
    : is_ctl ? PCRD_REG_CONTROL
    : is_oper ? PCRD_REG_OPERATIONAL
    : is_common ? PCRD_REG_COMMON
    : is_banked ? PCRD_REG_BANKED : PCRD_REG_SPECIAL;

  wire [7:0] rd_mux = eff_addr == `PCRD_ADDR_TIMER ? timer_reg
    : eff_addr == `PCRD_ADDR_PC ? pc_reg[7:0]
    : eff_addr == `PCRD_ADDR_STATUS ? {1'b0, page_reg, status_low_reg}
    : eff_addr == `PCRD_ADDR_POINTER ? ptr_reg
    : eff_addr == `PCRD_ADDR_PORT5 ? {7'h00, ctl_page_reg}
    : is_common ? common_reg[common_idx]
    : is_banked ? bank_reg[bank_sel][bank_idx] : `PCRD_BYTE_ZERO;
  wire [7:0] rd_data = is_ctl ? (ctl_page_reg ? `PCRD_BYTE_ZERO : pin_opt_reg) : rd_mux;

  // Program counter
  wire [11:0] pc_inc = pc_reg + 12'h001;
  wire [11:0] stack_top;
  wire is_call = flow.op == PCRD_OP_CALL;
  wire is_ret = flow.op == PCRD_OP_RET || flow.op == PCRD_OP_RET_LIT || flow.op == PCRD_OP_RET_INT;

  always_comb begin
    case (flow.op)
      PCRD_OP_JUMP: pc_next = {page_reg, flow.target}; // see RQ3 see RQ8 see RQ18
      PCRD_OP_CALL: pc_next = {page_reg, flow.target}; // see RQ4 see RQ8
      PCRD_OP_RET: pc_next = stack_top; // see RQ5
      PCRD_OP_RET_LIT: pc_next = stack_top; // see RQ5
      PCRD_OP_RET_INT: pc_next = stack_top; // see RQ5
      PCRD_OP_ADD_PC: pc_next = pc_reg + {4'h0, flow.acc}; // see RQ6
      PCRD_OP_MOVE_PC: pc_next = {pc_reg[11:8], flow.acc}; // see RQ7
      default: pc_next = wr_pc ? {pc_reg[11:8], access.wdata} : pc_inc;
    endcase
  end

  pcrd_return_stack u_stack (
    .clk(clk),
    .sys_rst(core_rst),
    .push(is_call), // see RQ4
    .pop(is_ret),
    .push_data(pc_inc),
    .top_data(stack_top)
  );

  assign timer_next = wr_timer ? access.wdata
    : (timer_ext_sel ? timer_reg + {7'h00, tpin_sync_reg & ~tpin_prev_reg} : timer_reg + 8'h01); // see RQ10

  always_ff @(posedge clk) begin
    if (core_rst) begin
      pc_reg <= `PCRD_PC_RESET; // see RQ1 see RQ2
      page_reg <= 2'h0;
      status_low_reg <= 5'h00;
      ptr_reg <= `PCRD_BYTE_ZERO;
      timer_reg <= `PCRD_BYTE_ZERO;
      ctl_page_reg <= 1'b0;
      pin_opt_reg <= `PCRD_PIN_OPT_RESET; // see RQ16
    end else begin
      pc_reg <= pc_next;
      timer_reg <= timer_next;
      if (wr_status) begin
        page_reg <= access.wdata[`PCRD_STATUS_PAGE_HI:`PCRD_STATUS_PAGE_LO]; // see RQ18 see RQ19
        status_low_reg <= access.wdata[4:0];
      end
      if (wr_ptr) ptr_reg <= access.wdata;
      if (wr_port5) ctl_page_reg <= access.wdata[`PCRD_PORT5_PAGE_BIT]; // see RQ21
      if (wr_pinopt) pin_opt_reg <= access.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (wr && is_common) common_reg[common_idx] <= access.wdata; // see RQ11
    if (wr && is_banked) bank_reg[bank_sel][bank_idx] <= access.wdata; // see RQ12
  end

  // Pin function priority
  always_ff @(posedge clk) begin
    if (core_rst) begin
      pin_out_reg <= 4'h0;
      pin_oe_reg <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pin_periph_out_en[i]) begin // see RQ14
          pin_out_reg[i] <= pin_periph_out[i];
          pin_oe_reg[i] <= 1'b1;
        end else if (pin_periph_in_en[i]) begin
          pin_out_reg[i] <= 1'b0;
          pin_oe_reg[i] <= 1'b0;
        end else begin
          pin_out_reg[i] <= pin_gpio_out[i];
          pin_oe_reg[i] <= pin_gpio_oe[i];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      rdata_reg <= `PCRD_BYTE_ZERO;
      decode_reg <= '0;
      in_reset_reg <= 1'b1;
    end else begin
      rdata_reg <= access.valid ? rd_data : rdata_reg; // see RQ9
      decode_reg <= '{region: region, bank: bank_sel, page: ctl_page_reg, addr: eff_addr};
      in_reset_reg <= 1'b0;
    end
  end

  assign program_counter = pc_reg;
  assign rdata = rdata_reg;
  assign decode_out = decode_reg;
  assign rom_page = page_reg;
  assign pointer_register = ptr_reg;
  assign timer_clock_counter = timer_reg;
  assign control_page_select = ctl_page_reg;
  assign pin_options = pin_opt_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;
  assign in_reset = in_reset_reg;

  a_pc_reset: assert property (@(posedge clk) core_rst |=> pc_reg == 12'h000) // see RQ1
    else $error("counter not cleared by reset");
  a_jump_load: assert property (@(posedge clk) disable iff (core_rst) // see RQ3
    flow.op == PCRD_OP_JUMP |=> pc_reg == {$past(page_reg), $past(flow.target)})
    else $error("jump target wrong");
  a_call_return: assert property (@(posedge clk) disable iff (core_rst) // see RQ4
    is_call ##1 is_ret |=> pc_reg == $past(pc_reg, 2) + 12'h001)
    else $error("return address wrong");
  a_ret_page_kept: assert property (@(posedge clk) disable iff (core_rst) // see RQ19
    is_ret && !wr_status |=> page_reg == $past(page_reg))
    else $error("return changed page");
  a_add_carry: assert property (@(posedge clk) disable iff (core_rst) // see RQ6
    flow.op == PCRD_OP_ADD_PC |=> pc_reg == $past(pc_reg) + {4'h0, $past(flow.acc)})
    else $error("relative add wrong");
  a_move_low: assert property (@(posedge clk) disable iff (core_rst) // see RQ7
    flow.op == PCRD_OP_MOVE_PC |=> pc_reg[11:8] == $past(pc_reg[11:8]) && pc_reg[7:0] == $past(flow.acc))
    else $error("move changed upper bits");
  a_timer_tick: assert property (@(posedge clk) disable iff (core_rst) // see RQ10
    !timer_ext_sel && !wr_timer |=> timer_reg == $past(timer_reg) + 8'h01)
    else $error("timer did not step");
  a_pin_priority: assert property (@(posedge clk) disable iff (core_rst) // see RQ14
    pin_periph_out_en[0] |=> pin_oe[0] && pin_out[0] == $past(pin_periph_out[0]))
    else $error("peripheral output lost priority");
  a_ext_reset: assert property (@(posedge clk) !ext_rst_n [*3] |=> in_reset) // see RQ17
    else $error("reset pin ignored");
  a_pinopt_reset: assert property (@(posedge clk) core_rst |=> pin_options == 8'h00) // see RQ16
    else $error("pin options not cleared");
  a_in_reset_low: assert property (@(posedge clk) !core_rst |=> !in_reset) // see RQ17
    else $error("reset flag stuck high");

  // Flow sequencing checks
  a_call_target: assert property (@(posedge clk) disable iff (core_rst) // see RQ4
    is_call |=> pc_reg == {$past(page_reg), $past(flow.target)})
    else $error("call target wrong");
  a_ret_top: assert property (@(posedge clk) disable iff (core_rst) // see RQ5
    is_ret |=> pc_reg == $past(stack_top))
    else $error("return not from stack top");
  a_step_inc: assert property (@(posedge clk) disable iff (core_rst) // see RQ2
    flow.op == PCRD_OP_STEP && !wr_pc |=> pc_reg == $past(pc_reg) + 12'h001)
    else $error("counter did not step");
  a_pc_write: assert property (@(posedge clk) disable iff (core_rst) // see RQ1
    flow.op == PCRD_OP_STEP && wr_pc |=> pc_reg == {$past(pc_reg[11:8]), $past(access.wdata)})
    else $error("counter low byte write lost");

  // Register map and decode checks
  a_indirect_addr: assert property (@(posedge clk) disable iff (core_rst) // see RQ9
    access.valid && is_indirect |=> decode_out.addr == $past(ptr_reg[5:0]))
    else $error("indirect access not through pointer");
  a_common_read: assert property (@(posedge clk) disable iff (core_rst) // see RQ11
    access.valid && !access.write && is_common |=> rdata == $past(common_reg[common_idx]))
    else $error("common register read wrong");
  a_bank_read: assert property (@(posedge clk) disable iff (core_rst) // see RQ12
    access.valid && !access.write && is_banked |=> rdata == $past(bank_reg[bank_sel][bank_idx]))
    else $error("banked register read wrong");
  a_bank_select: assert property (@(posedge clk) disable iff (core_rst) // see RQ20
    access.valid && is_banked |=> decode_out.bank == $past(ptr_reg[`PCRD_PTR_BANK_HI:`PCRD_PTR_BANK_LO]))
    else $error("bank not taken from pointer");
  a_oper_region: assert property (@(posedge clk) disable iff (core_rst) // see RQ13
    access.valid && is_oper && !is_ctl && !is_indirect |=> decode_out.region == PCRD_REG_OPERATIONAL)
    else $error("operational region wrong");
  a_ctl_region: assert property (@(posedge clk) disable iff (core_rst) // see RQ13
    access.valid && is_ctl && !is_indirect |=> decode_out.region == PCRD_REG_CONTROL)
    else $error("control region wrong");
  a_page_write: assert property (@(posedge clk) disable iff (core_rst) // see RQ18
    wr_status |=> rom_page == $past(access.wdata[`PCRD_STATUS_PAGE_HI:`PCRD_STATUS_PAGE_LO]))
    else $error("page select write lost");
  a_ctl_page_write: assert property (@(posedge clk) disable iff (core_rst) // see RQ21
    wr_port5 |=> control_page_select == $past(access.wdata[`PCRD_PORT5_PAGE_BIT]))
    else $error("control page write lost");
  a_ctl_page1_drop: assert property (@(posedge clk) disable iff (core_rst) // see RQ21
    access.valid && access.write && is_ctl && ctl_page_reg |=> pin_options == $past(pin_options))
    else $error("page one write reached pin options");
  a_pinopt_write: assert property (@(posedge clk) disable iff (core_rst) // see RQ16
    wr_pinopt |=> pin_options == $past(access.wdata))
    else $error("pin options write lost");
  a_timer_write: assert property (@(posedge clk) disable iff (core_rst) // see RQ10
    wr_timer |=> timer_clock_counter == $past(access.wdata))
    else $error("timer write lost");
  a_timer_hold: assert property (@(posedge clk) disable iff (core_rst) // see RQ10
    timer_ext_sel && !wr_timer && !(tpin_sync_reg && !tpin_prev_reg) |=> timer_reg == $past(timer_reg))
    else $error("timer moved without pin edge");
  c_call_ret: cover property (@(posedge clk) is_call ##[1:8] is_ret);
  c_indirect: cover property (@(posedge clk) access.valid && is_indirect && is_banked);
  c_ctl_page1: cover property (@(posedge clk) access.valid && is_ctl && ctl_page_reg);
  c_add_carry: cover property (@(posedge clk) flow.op == PCRD_OP_ADD_PC && pc_reg[7:0] == 8'hFF);
  c_pc_write: cover property (@(posedge clk) wr_pc && flow.op == PCRD_OP_STEP);
endmodule : pcrd_core

// *** tb/pcrd_decoder_model.sv ***
// Instruction decoder stand-in that issues flow ops to the core
`timescale 1ns/100ps
module pcrd_decoder_model import pcrd_pkg::*; (
  input wire logic clk, // Instruction clock
  output pcrd_flow_t flow // Flow request to the core
);
  initial flow = '{op: PCRD_OP_STEP, target: 10'h000, acc: 8'h00};

  // One op per edge; unless chained, plain stepping follows
  task automatic issue(input pcrd_op_t op, input logic [9:0] target, input logic [7:0] acc,
    input bit chain = 1'b0);
    flow = '{op: op, target: target, acc: acc};
    @(posedge clk);
    #1;
    if (!chain) flow.op = PCRD_OP_STEP;
  endtask : issue
endmodule : pcrd_decoder_model

// *** tb/testbench.sv ***
// Self-checking bench for the program counter and register decode block
`timescale 1ns/100ps
`include "pcrd_consts.svh"
module testbench import pcrd_pkg::*;;
  logic clk, sys_rst, ext_rst_n, timer_pin, timer_ext_sel, control_page_select, in_reset;
  pcrd_flow_t flow;
  pcrd_access_t access;
  logic [3:0] p_oe_en, p_in_en, p_out, g_out, g_oe, pin_out, pin_oe;
  logic [11:0] program_counter, exp_pc, ra;
  logic [7:0] rdata, pointer_register, timer_clock_counter, pin_options, rq;
  logic [1:0] rom_page, page_m;
  pcrd_decode_t decode_out, dq;
  logic [11:0] stk [8];
  logic [2:0] sp;
  pcrd_op_t rk;
  int errors = 0;
  int check_count = 0;

  pcrd_decoder_model dec (.clk(clk), .flow(flow));
  pcrd_core dut (.clk(clk), .sys_rst(sys_rst), .ext_rst_n(ext_rst_n), .timer_pin(timer_pin),
    .timer_ext_sel(timer_ext_sel), .flow(flow), .access(access), .pin_periph_out_en(p_oe_en),
    .pin_periph_in_en(p_in_en), .pin_periph_out(p_out), .pin_gpio_out(g_out), .pin_gpio_oe(g_oe),
    .program_counter(program_counter), .rdata(rdata), .decode_out(decode_out), .rom_page(rom_page),
    .pointer_register(pointer_register), .timer_clock_counter(timer_clock_counter),
    .control_page_select(control_page_select), .pin_options(pin_options), .pin_out(pin_out),
    .pin_oe(pin_oe), .in_reset(in_reset));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Reference counter and return stack
  always @(posedge clk) begin
    if (sys_rst) begin
      exp_pc <= 12'h000;
      sp <= 3'h0;
    end else begin
      case (flow.op)
        PCRD_OP_JUMP: exp_pc <= {page_m, flow.target};
        PCRD_OP_CALL: begin
          exp_pc <= {page_m, flow.target};
          stk[sp] <= exp_pc + 12'h001;
          sp <= sp + 3'h1;
        end
        PCRD_OP_RET, PCRD_OP_RET_LIT, PCRD_OP_RET_INT: begin
          exp_pc <= stk[sp - 3'h1];
          sp <= sp - 3'h1;
        end
        PCRD_OP_ADD_PC: exp_pc <= exp_pc + {4'h0, flow.acc};
        PCRD_OP_MOVE_PC: exp_pc <= {exp_pc[11:8], flow.acc};
        default: exp_pc <= exp_pc + 12'h001;
      endcase
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic acc_op(input logic ctrl, input logic [5:0] addr, input logic wr, input logic [7:0] wd);
    access = '{valid: 1'b1, control_space: ctrl, addr: addr, write: wr, wdata: wd};
    @(posedge clk);
    #1 dq = decode_out;
    access.valid = 1'b0;
    @(posedge clk);
    #1 rq = rdata;
  endtask : acc_op

  task automatic report_and_stop;
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    #20000;
    errors++;
    report_and_stop();
  end

  initial begin
    sys_rst = 1'b1;
    ext_rst_n = 1'b1;
    timer_pin = 1'b0;
    timer_ext_sel = 1'b1;
    access = '0;
    page_m = 2'h0;
    {p_oe_en, p_in_en, p_out, g_out, g_oe} = 20'h00000;
    repeat (6) @(posedge clk);
    #1 chk(program_counter, 12'h000);
    chk(pin_options, `PCRD_PIN_OPT_RESET);
    sys_rst = 1'b0;
    for (int p = 0; p < 4; p++) begin
      page_m = p[1:0];
      acc_op(1'b0, `PCRD_ADDR_STATUS, 1'b1, {1'b0, p[1:0], 5'h00});
      chk(rom_page, p);
      dec.issue(PCRD_OP_JUMP, 10'h2A5, 8'h00);
      chk(program_counter, {p[1:0], 10'h2A5});
    end
    // Each return kind, with the page moved away before returning
    for (int k = 0; k < 3; k++) begin
      ra = exp_pc + 12'h001;
      dec.issue(PCRD_OP_CALL, 10'h0F0, 8'h00);
      chk(program_counter, 12'hCF0);
      acc_op(1'b0, `PCRD_ADDR_STATUS, 1'b1, 8'h00);
      page_m = 2'h0;
      rk = pcrd_op_t'(3'(3 + k));
      dec.issue(rk, 10'h000, 8'h00);
      chk(program_counter, ra);
      acc_op(1'b0, `PCRD_ADDR_STATUS, 1'b1, 8'h60);
      page_m = 2'h3;
    end
    acc_op(1'b0, `PCRD_ADDR_STATUS, 1'b1, 8'h00);
    page_m = 2'h0;
    dec.issue(PCRD_OP_JUMP, 10'h0F0, 8'h00, 1'b1);
    dec.issue(PCRD_OP_ADD_PC, 10'h000, 8'h25, 1'b1);
    chk(program_counter, 12'h115);
    dec.issue(PCRD_OP_MOVE_PC, 10'h000, 8'h3C, 1'b1);
    chk(program_counter, 12'h13C);
    // Nine nested calls overrun the stack and wrap
    for (int i = 0; i < 9; i++) dec.issue(PCRD_OP_CALL, 10'(i * 7), 8'h00, 1'b1);
    for (int i = 0; i < 9; i++) begin
      dec.issue(PCRD_OP_RET, 10'h000, 8'h00, i < 8);
      chk(program_counter, exp_pc);
    end
    acc_op(1'b0, `PCRD_ADDR_POINTER, 1'b1, 8'h80);
    chk(pointer_register, 8'h80);
    acc_op(1'b0, 6'h2A, 1'b1, 8'h3C);
    chk({dq.region, dq.bank}, {PCRD_REG_BANKED, 2'h2});
    acc_op(1'b0, `PCRD_ADDR_POINTER, 1'b1, 8'h40);
    acc_op(1'b0, 6'h2A, 1'b1, 8'hC3);
    acc_op(1'b0, 6'h15, 1'b1, 8'h99);
    chk(dq.region, PCRD_REG_COMMON);
    acc_op(1'b0, `PCRD_ADDR_POINTER, 1'b1, 8'hAA);
    acc_op(1'b0, `PCRD_ADDR_INDIRECT, 1'b0, 8'h00);
    chk({dq.addr, rq}, {6'h2A, 8'h3C});
    acc_op(1'b0, 6'h15, 1'b0, 8'h00);
    chk(rq, 8'h99);
    acc_op(1'b0, 6'h07, 1'b0, 8'h00);
    chk(dq.region, PCRD_REG_OPERATIONAL);
    acc_op(1'b1, 6'h0B, 1'b1, 8'h5A);
    chk({dq.region, pin_options}, {PCRD_REG_CONTROL, 8'h5A});
    acc_op(1'b0, `PCRD_ADDR_PORT5, 1'b1, 8'h01);
    chk(control_page_select, 1'b1);
    acc_op(1'b1, 6'h0B, 1'b1, 8'hFF);
    chk({dq.page, pin_options}, {1'b1, 8'h5A});
    acc_op(1'b0, `PCRD_ADDR_TIMER, 1'b1, 8'hF0);
    repeat (3) begin
      timer_pin = 1'b1;
      repeat (3) @(posedge clk);
      #1 timer_pin = 1'b0;
      repeat (3) @(posedge clk);
      #1;
    end
    repeat (4) @(posedge clk);
    #1 chk(timer_clock_counter, 8'hF3);
    timer_ext_sel = 1'b0;
    repeat (6) @(posedge clk);
    #1 chk(timer_clock_counter, 8'hF9);
    // Peripheral pins keep wake-up off; only priority is driven here
    {p_oe_en, p_in_en, p_out, g_out, g_oe} = {4'h9, 4'hA, 4'h1, 4'hE, 4'hF};
    repeat (2) @(posedge clk);
    #1 chk({pin_oe, pin_out & pin_oe}, {4'hD, 4'h5});
    ra = exp_pc;
    acc_op(1'b0, `PCRD_ADDR_PC, 1'b0, 8'h00);
    chk(rq, ra[7:0]);
    ra = exp_pc;
    acc_op(1'b0, `PCRD_ADDR_PC, 1'b1, 8'h77);
    chk(program_counter, {ra[11:8], 8'h78});
    ext_rst_n = 1'b0;
    repeat (6) @(posedge clk);
    #1 chk({in_reset, program_counter}, {1'b1, 12'h000});
    ext_rst_n = 1'b1;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk({in_reset, pointer_register, program_counter}, {1'b0, 8'h00, exp_pc});
    report_and_stop();
  end
endmodule : testbench
